// *** ufn_cfg.svh ***
// offsets, field positions and reset values of the frame/irq block
// assumes APB with 32-bit data, one register per aligned word
`ifndef UFN_CFG_SVH
`define UFN_CFG_SVH

// -----------------------------------------------------------------------------
// register indices as printed
// -----------------------------------------------------------------------------
`define UFN_IDX_IN_FLAGS 8'h02
`define UFN_IDX_FRAME_LO 8'h0C
`define UFN_IDX_FRAME_HI 8'h0D
`define UFN_IDX_IRQ_EN 8'h10
`define UFN_IDX_CTRL_EN 8'h11
`define UFN_IDX_IRQ_STAT 8'h12
`define UFN_IDX_IRQ_MASK 8'h13

// -----------------------------------------------------------------------------
// fields and reset values
// -----------------------------------------------------------------------------
`define UFN_IN_EP_COUNT 4
`define UFN_FRAME_W 11
`define UFN_RST_IN_FLAGS 8'h00
`define UFN_RST_FRAME 11'h000
`define UFN_RST_IRQ_EN 4'h0
`define UFN_RST_CTRL_EN 1'h0
`define UFN_RST_STAT 2'h0
`define UFN_RST_MASK 2'h0
`define UFN_STAT_SOF_BIT 0
`define UFN_STAT_IN_BIT 1

`endif

// *** ufn_pkg.sv ***
// types of the frame number and irq flag block
// assumes the constants of ufn_cfg.svh
package ufn_pkg;

    typedef enum logic [1:0]
    {
        UFN_APB_IDLE,
        UFN_APB_ACCESS
    } ufn_apb_state_t;

endpackage

// *** ufn_frame_irq.sv ***
// frame number capture and irq flag registers of the usb function controller
// assumes a same-clock token decoder delivering sof and in-endpoint event pulses
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`include "ufn_cfg.svh"

module ufn_frame_irq
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // events from the token decoder
    input wire logic sof_valid,
    input wire logic [10:0] sof_frame,
    input wire logic [3:0] in_ep_done,
    // interrupts
    output logic usb_irq,
    output logic cpu_irq
);

    // -------------------------------------------------------------------------
    // bus decode
    // -------------------------------------------------------------------------
    ufn_pkg::ufn_apb_state_t apb_state_q;
    logic setup;
    logic access;
    logic rd_acc;
    logic wr_acc;
    logic [9:0] word_idx;
    logic hit_in;
    logic hit_flo;
    logic hit_fhi;
    logic hit_en;
    logic hit_cen;
    logic hit_stat;
    logic hit_mask;
    logic mapped;

    assign setup = psel && !penable;
    assign access = psel && penable && (apb_state_q == ufn_pkg::UFN_APB_ACCESS);
    assign pready = 1'b1;
    assign rd_acc = access && !pwrite;
    assign wr_acc = access && pwrite;
    assign word_idx = paddr[11:2];
    assign hit_in = (paddr[1:0] == 2'h0) && (word_idx == {2'h0, `UFN_IDX_IN_FLAGS});
    assign hit_flo = (paddr[1:0] == 2'h0) && (word_idx == {2'h0, `UFN_IDX_FRAME_LO});
    assign hit_fhi = (paddr[1:0] == 2'h0) && (word_idx == {2'h0, `UFN_IDX_FRAME_HI});
    assign hit_en = (paddr[1:0] == 2'h0) && (word_idx == {2'h0, `UFN_IDX_IRQ_EN});
    assign hit_cen = (paddr[1:0] == 2'h0) && (word_idx == {2'h0, `UFN_IDX_CTRL_EN});
    assign hit_stat = (paddr[1:0] == 2'h0) && (word_idx == {2'h0, `UFN_IDX_IRQ_STAT});
    assign hit_mask = (paddr[1:0] == 2'h0) && (word_idx == {2'h0, `UFN_IDX_IRQ_MASK});
    assign mapped = hit_in || hit_flo || hit_fhi || hit_en || hit_cen || hit_stat || hit_mask;
    assign pslverr = access && !mapped;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            apb_state_q <= ufn_pkg::UFN_APB_IDLE;
        else if (setup)
            apb_state_q <= ufn_pkg::UFN_APB_ACCESS;
        else
            apb_state_q <= ufn_pkg::UFN_APB_IDLE;
    end

    // -------------------------------------------------------------------------
    // frame number capture
    // -------------------------------------------------------------------------
    logic [10:0] frame_q;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            frame_q <= `UFN_RST_FRAME;
        else if (sof_valid)
            frame_q <= sof_frame;
    end

    // -------------------------------------------------------------------------
    // in-endpoint pending flags, clear on read
    // -------------------------------------------------------------------------
    logic [3:0] in_pend_q;
    logic in_rd;

    assign in_rd = rd_acc && hit_in;

    generate
        for (genvar g = 0; g < `UFN_IN_EP_COUNT; g++)
        begin : g_in_flag
            always_ff @(posedge ref_clk)
            begin
                if (sys_rst)
                    in_pend_q[g] <= 1'b0;
                else if (in_ep_done[g])
                    in_pend_q[g] <= 1'b1;
                else if (in_rd)
                    in_pend_q[g] <= 1'b0;
            end
        end
    endgenerate

    // -------------------------------------------------------------------------
    // enables and combined interrupt
    // -------------------------------------------------------------------------
    logic [3:0] irq_en_q;
    logic ctrl_en_q;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            irq_en_q <= `UFN_RST_IRQ_EN;
        else if (wr_acc && hit_en)
            irq_en_q <= pwdata[3:0];
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            ctrl_en_q <= `UFN_RST_CTRL_EN;
        else if (wr_acc && hit_cen)
            ctrl_en_q <= pwdata[0];
    end

    assign usb_irq = |(in_pend_q & irq_en_q);
    assign cpu_irq = usb_irq && ctrl_en_q;

    // -------------------------------------------------------------------------
    // sticky event status, write one to clear
    // -------------------------------------------------------------------------
    logic [1:0] stat_q;
    logic [1:0] mask_q;
    logic [1:0] stat_evt;

    assign stat_evt = {|in_ep_done, sof_valid};

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            stat_q <= `UFN_RST_STAT;
        else if (wr_acc && hit_stat)
            stat_q <= (stat_q & ~pwdata[1:0]) | stat_evt;
        else
            stat_q <= stat_q | stat_evt;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            mask_q <= `UFN_RST_MASK;
        else if (wr_acc && hit_mask)
            mask_q <= pwdata[1:0];
    end

    // -------------------------------------------------------------------------
    // read data
    // -------------------------------------------------------------------------
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;

    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (hit_in)
            rdata_d = {28'h000_0000, in_pend_q};
        else if (hit_flo)
            rdata_d = {24'h00_0000, frame_q[7:0]};
        else if (hit_fhi)
            rdata_d = {29'h0, frame_q[10:8]};
        else if (hit_en)
            rdata_d = {28'h000_0000, irq_en_q};
        else if (hit_cen)
            rdata_d = {31'h0, ctrl_en_q};
        else if (hit_stat)
            rdata_d = {30'h0, stat_q};
        else if (hit_mask)
            rdata_d = {30'h0, mask_q};
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            rdata_q <= 32'h0000_0000;
        else if (setup && !pwrite)
            rdata_q <= rdata_d;
    end

    assign prdata = rdata_q;

    // -------------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------------
    property p_frame_capture;
        @(posedge ref_clk) disable iff (sys_rst)
        sof_valid |=> frame_q == $past(sof_frame);
    endproperty
    a_frame_capture: assert property (p_frame_capture) else $error("frame not captured");

    property p_frame_high;
        @(posedge ref_clk) disable iff (sys_rst)
        (setup && !pwrite && hit_fhi) |=> prdata[31:3] == 29'h0 && prdata[2:0] == $past(frame_q[10:8]);
    endproperty
    a_frame_high: assert property (p_frame_high) else $error("high frame read wrong");

    property p_frame_high_wr;
        @(posedge ref_clk) disable iff (sys_rst)
        (wr_acc && hit_fhi && !sof_valid) |=> $stable(frame_q);
    endproperty
    a_frame_high_wr: assert property (p_frame_high_wr) else $error("frame written");

    property p_flags_ro;
        @(posedge ref_clk) disable iff (sys_rst)
        (wr_acc && hit_in && in_ep_done == 4'h0) |=> $stable(in_pend_q);
    endproperty
    a_flags_ro: assert property (p_flags_ro) else $error("flag register written");

    property p_irq_any;
        @(posedge ref_clk) disable iff (sys_rst)
        usb_irq == |(in_pend_q & irq_en_q);
    endproperty
    a_irq_any: assert property (p_irq_any) else $error("irq mismatch");

    property p_clear_on_read;
        @(posedge ref_clk) disable iff (sys_rst)
        (in_rd && in_ep_done == 4'h0) |=> in_pend_q == 4'h0 && !usb_irq;
    endproperty
    a_clear_on_read: assert property (p_clear_on_read) else $error("flags not cleared");

    property p_cpu_gate;
        @(posedge ref_clk) disable iff (sys_rst)
        cpu_irq |-> ctrl_en_q && (in_pend_q != 4'h0);
    endproperty
    a_cpu_gate: assert property (p_cpu_gate) else $error("cpu irq ungated");

    property p_in_set;
        @(posedge ref_clk) disable iff (sys_rst)
        in_ep_done != 4'h0 |=> (in_pend_q & $past(in_ep_done)) == $past(in_ep_done);
    endproperty
    a_in_set: assert property (p_in_set) else $error("pending not set");

    property p_frame_low;
        @(posedge ref_clk) disable iff (sys_rst)
        (setup && !pwrite && hit_flo) |=> prdata == {24'h00_0000, $past(frame_q[7:0])};
    endproperty
    a_frame_low: assert property (p_frame_low) else $error("low frame read wrong");

    property p_frame_low_wr;
        @(posedge ref_clk) disable iff (sys_rst)
        (wr_acc && hit_flo && !sof_valid) |=> $stable(frame_q);
    endproperty
    a_frame_low_wr: assert property (p_frame_low_wr) else $error("low frame written");

    property p_in_upper_zero;
        @(posedge ref_clk) disable iff (sys_rst)
        (setup && !pwrite && hit_in) |=> prdata[31:4] == 28'h000_0000;
    endproperty
    a_in_upper_zero: assert property (p_in_upper_zero) else $error("flag upper bits set");

    property p_set_wins;
        @(posedge ref_clk) disable iff (sys_rst)
        (in_rd && in_ep_done != 4'h0) |=> (in_pend_q & $past(in_ep_done)) == $past(in_ep_done);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost on read");

    property p_en_separate;
        @(posedge ref_clk) disable iff (sys_rst)
        (wr_acc && hit_en) |=> $stable(in_pend_q) || $past(in_ep_done) != 4'h0;
    endproperty
    a_en_separate: assert property (p_en_separate) else $error("enable write hit flags");

    property p_any_flag;
        @(posedge ref_clk) disable iff (sys_rst)
        (in_pend_q != 4'h0 && irq_en_q == 4'hF) |-> usb_irq;
    endproperty
    a_any_flag: assert property (p_any_flag) else $error("flag set without irq");

    property p_irq_source;
        @(posedge ref_clk) disable iff (sys_rst)
        usb_irq |-> in_pend_q != 4'h0;
    endproperty
    a_irq_source: assert property (p_irq_source) else $error("irq without flag");

    property p_cpu_off;
        @(posedge ref_clk) disable iff (sys_rst)
        !ctrl_en_q |-> !cpu_irq;
    endproperty
    a_cpu_off: assert property (p_cpu_off) else $error("cpu irq while disabled");

    property p_cpu_on;
        @(posedge ref_clk) disable iff (sys_rst)
        (usb_irq && ctrl_en_q) |-> cpu_irq;
    endproperty
    a_cpu_on: assert property (p_cpu_on) else $error("cpu irq missing");

    property p_stat_set;
        @(posedge ref_clk) disable iff (sys_rst)
        sof_valid |=> stat_q[`UFN_STAT_SOF_BIT];
    endproperty
    a_stat_set: assert property (p_stat_set) else $error("sof status not set");

    property p_stat_clear;
        @(posedge ref_clk) disable iff (sys_rst)
        (wr_acc && hit_stat && pwdata[`UFN_STAT_SOF_BIT] && !sof_valid) |=> !stat_q[`UFN_STAT_SOF_BIT];
    endproperty
    a_stat_clear: assert property (p_stat_clear) else $error("sof status not cleared");

    property p_unmapped_rd;
        @(posedge ref_clk) disable iff (sys_rst)
        (setup && !pwrite && !mapped) |=> prdata == 32'h0000_0000;
    endproperty
    a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");

    property p_rdata_hold;
        @(posedge ref_clk) disable iff (sys_rst)
        !(setup && !pwrite) |=> $stable(prdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

    // -------------------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------------------

    c_sof: cover property (@(posedge ref_clk) disable iff (sys_rst) sof_valid ##1 (rd_acc && hit_flo));
    c_sof_hi: cover property (@(posedge ref_clk) disable iff (sys_rst) sof_valid ##1 (rd_acc && hit_fhi));
    c_set_wins: cover property (@(posedge ref_clk) disable iff (sys_rst) in_rd && in_ep_done != 4'h0);
    c_irq: cover property (@(posedge ref_clk) disable iff (sys_rst) $rose(cpu_irq));
    c_clear: cover property (@(posedge ref_clk) disable iff (sys_rst) usb_irq ##1 in_rd ##1 !usb_irq);

endmodule

// *** ufn_host_model.sv ***
// usb host side model: start-of-frame and in-token events
// assumes a token decoder in the same clock domain
`timescale 1ns/10ps

module ufn_host_model
(
    // clock
    input wire logic ref_clk,
    // events
    output logic sof_valid,
    output logic [10:0] sof_frame,
    output logic [3:0] in_ep_done
);
    initial
    begin
        sof_valid = 1'b0;
        sof_frame = 11'h7FF;
        in_ep_done = 4'h0;
    end

    // frame field is scrambled outside the pulse
    task automatic send_sof(input logic [10:0] f);
        @(posedge ref_clk);
        sof_valid <= 1'b1;
        sof_frame <= f;
        @(posedge ref_clk);
        sof_valid <= 1'b0;
        sof_frame <= ~f;
    endtask

    task automatic send_in(input logic [3:0] m);
        @(posedge ref_clk);
        in_ep_done <= m;
        @(posedge ref_clk);
        in_ep_done <= 4'h0;
    endtask
endmodule

// *** tb_top.sv ***
// self-checking bench of the frame number and irq flag block
// assumes zero-wait apb slave and the host model beside it
`timescale 1ns/10ps

module tb_top;
    logic ref_clk = 1'b0;
    logic sys_rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sof_valid;
    logic [10:0] sof_frame;
    logic [3:0] in_ep_done;
    logic usb_irq;
    logic cpu_irq;
    int failures = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic er;

    always #5 ref_clk = ~ref_clk;

    ufn_frame_irq i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sof_valid(sof_valid), .sof_frame(sof_frame), .in_ep_done(in_ep_done),
        .usb_irq(usb_irq), .cpu_irq(cpu_irq));

    ufn_host_model i_host (.ref_clk(ref_clk), .sof_valid(sof_valid), .sof_frame(sof_frame),
        .in_ep_done(in_ep_done));

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            failures++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, rd, e);
    endtask

    task automatic irqchk(input logic u, input logic c);
        @(posedge ref_clk);
        chk("usb_irq", {31'h0, usb_irq}, {31'h0, u});
        chk("cpu_irq", {31'h0, cpu_irq}, {31'h0, c});
    endtask

    // ---------------------------------------------------------------
    // timeout and main sequence
    // ---------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            failures++;
            conclude();
        end
    end

    initial
    begin
        sys_rst <= 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 12'h000;
        pwdata <= 32'h0;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rdchk("in_flags", 12'h008, 32'h0);
        rdchk("frame_lo", 12'h030, 32'h0);
        rdchk("frame_hi", 12'h034, 32'h0);
        irqchk(1'b0, 1'b0);
        i_host.send_sof(11'h5A3);
        rdchk("frame_lo", 12'h030, 32'hA3);
        rdchk("frame_hi", 12'h034, 32'h05);
        apb(1'b1, 12'h030, 32'hFFFFFFFF);
        apb(1'b1, 12'h034, 32'hFFFFFFFF);
        rdchk("frame_lo", 12'h030, 32'hA3);
        rdchk("frame_hi", 12'h034, 32'h05);
        i_host.send_sof(11'h7FF);
        rdchk("frame_hi", 12'h034, 32'h07);
        for (int i = 0; i < 4; i++)
        begin
            i_host.send_in(4'h1 << i);
            rdchk("in_flags", 12'h008, 32'h1 << i);
            rdchk("in_flags", 12'h008, 32'h0);
        end
        i_host.send_in(4'hF);
        apb(1'b1, 12'h008, 32'h0);
        rdchk("in_flags", 12'h008, 32'h0F);
        rdchk("stat", 12'h048, 32'h3);
        apb(1'b1, 12'h048, 32'h1);
        rdchk("stat", 12'h048, 32'h2);
        apb(1'b1, 12'h04C, 32'h3);
        rdchk("mask", 12'h04C, 32'h3);
        apb(1'b1, 12'h040, 32'hF);
        rdchk("irq_en", 12'h040, 32'hF);
        i_host.send_in(4'h4);
        irqchk(1'b1, 1'b0);
        apb(1'b1, 12'h044, 32'h1);
        irqchk(1'b1, 1'b1);
        rdchk("in_flags", 12'h008, 32'h04);
        irqchk(1'b0, 1'b0);
        apb(1'b1, 12'h040, 32'hB);
        i_host.send_in(4'h4);
        irqchk(1'b0, 1'b0);
        i_host.send_in(4'h8);
        irqchk(1'b1, 1'b1);
        apb(1'b0, 12'h3FC, 32'h0);
        chk("unmapped_err", {31'h0, er}, 32'h1);
        chk("unmapped_rd", rd, 32'h0);
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rdchk("frame_lo", 12'h030, 32'h0);
        rdchk("in_flags", 12'h008, 32'h0);
        irqchk(1'b0, 1'b0);
        conclude();
    end
endmodule
